// >>> adc_port_pkg.sv
`default_nettype none
package adc_port_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] CTRL_ADDR    = 8'h00;
	localparam logic [7:0] STATUS_ADDR  = 8'h04;
	localparam logic [7:0] OFS_L_ADDR   = 8'h08;
	localparam logic [7:0] OFS_R_ADDR   = 8'h0C;
	localparam logic [7:0] PEAK_ADDR    = 8'h10;
	localparam logic [7:0] CMD_ADDR     = 8'h14;
	// ==========================================================
	// Control field positions
	localparam int CTRL_OS_HI    = 0;
	localparam int CTRL_I2S      = 1;
	localparam int CTRL_SLAVE    = 2;
	localparam int CTRL_HPF_BYP  = 3;
	localparam int CTRL_BARGRAPH = 4;
	localparam int CTRL_PEAK_APPEND_EN = 6;
	localparam int CMD_FILTER_START    = 0;
	localparam int CMD_PEAK_UPDATE     = 1;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// ==========================================================
	// Timing counts
	localparam int BCLK_DIV      = 4;
	localparam int FRAME_DIV_LO  = 256;
	localparam int FRAME_DIV_HI  = 512;
	localparam int WORD_BITS     = 24;
	localparam int PEAK_BITS     = 8;
	localparam int HPF_SHIFT     = 12;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic        bclk;
		logic        frame;
		logic        frame_edge;
		logic        bclk_fall;
	} clk_bus_t;

	typedef struct packed {
		logic signed [23:0] left;
		logic signed [23:0] right;
	} stereo_t;
endpackage
`default_nettype wire

// >>> adc_serial_audio_port_ctrl.sv
`default_nettype none
module adc_serial_audio_port_ctrl
	import adc_port_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               rstn,
	// AXI4-Lite slave
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// Decimator samples
	input  wire logic               sample_valid,
	input  wire logic signed [23:0] full_left,
	input  wire logic signed [23:0] full_right,
	input  wire logic signed [23:0] lgd_left,
	input  wire logic signed [23:0] lgd_right,
	input  wire logic               ovf_left,
	input  wire logic               ovf_right,
	output logic [1:0]              decim_sel,
	output logic                    filter_resync,
	// Serial pins
	input  wire logic               bit_clock_in,
	output logic                    bit_clock_out,
	output logic                    bit_clock_oe_n,
	input  wire logic               frame_clock_in,
	output logic                    frame_clock,
	output logic                    frame_clock_oe_n,
	output logic                    full_precision_out,
	output logic                    secondary_audio_out
);
	// ==========================================================
	// Register state
	logic [7:0]         ctrl_q;
	logic signed [23:0] ofs_l_q;
	logic signed [23:0] ofs_r_q;
	logic               filter_start_q;
	logic               peak_update_q;
	logic [7:0]         peak_l_w;
	logic [7:0]         peak_r_w;
	clk_bus_t           clks;

	// ==========================================================
	// AXI write path: address and data taken in either order
	logic       aw_hold_q;
	logic       w_hold_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic       aw_take;
	logic       w_take;
	logic       wr_fire;
	logic [7:0] wa_w;
	logic [31:0] wd_w;
	logic [3:0] ws_w;
	logic       wr_ok;

	assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take  = s_axi_wvalid && s_axi_wready;
	assign wr_fire = (aw_hold_q || aw_take) && (w_hold_q || w_take);
	assign wa_w = aw_hold_q ? awaddr_q : s_axi_awaddr;
	assign wd_w = w_hold_q ? wdata_q : s_axi_wdata;
	assign ws_w = w_hold_q ? wstrb_q : s_axi_wstrb;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= CMD_ADDR);
	endfunction
	assign wr_ok = mapped(wa_w) && wa_w != STATUS_ADDR && wa_w != PEAK_ADDR;

	// Write handshake tracking and response
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (aw_take)
				awaddr_q <= s_axi_awaddr;
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			aw_hold_q <= wr_fire ? 1'b0 : (aw_hold_q | aw_take);
			w_hold_q <= wr_fire ? 1'b0 : (w_hold_q | w_take);
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RESET;
			ofs_l_q <= 24'sh00_0000;
			ofs_r_q <= 24'sh00_0000;
			filter_start_q <= 1'b0;
			peak_update_q <= 1'b0;
		end else begin
			filter_start_q <= wr_fire && wa_w == CMD_ADDR && ws_w[0] && wd_w[CMD_FILTER_START];
			peak_update_q <= wr_fire && wa_w == CMD_ADDR && ws_w[0] && wd_w[CMD_PEAK_UPDATE];
			if (wr_fire && wa_w == CTRL_ADDR && ws_w[0])
				ctrl_q <= wd_w[7:0];
			for (int b = 0; b < 3; b++) begin
				if (wr_fire && wa_w == OFS_L_ADDR && ws_w[b])
					ofs_l_q[b*8 +: 8] <= wd_w[b*8 +: 8];
				if (wr_fire && wa_w == OFS_R_ADDR && ws_w[b])
					ofs_r_q[b*8 +: 8] <= wd_w[b*8 +: 8];
			end
		end
	end

	// ==========================================================
	// AXI read path, one cycle to rvalid
	logic [31:0] rd_w;
	assign rd_w = (s_axi_araddr == CTRL_ADDR)   ? {24'h00_0000, ctrl_q} :
		(s_axi_araddr == STATUS_ADDR) ? {29'h0000_0000, clks.frame, clks.bclk,
			ctrl_q[CTRL_OS_HI]} :
		(s_axi_araddr == OFS_L_ADDR)  ? {8'h00, ofs_l_q} :
		(s_axi_araddr == OFS_R_ADDR)  ? {8'h00, ofs_r_q} :
		(s_axi_araddr == PEAK_ADDR)   ? {16'h0000, peak_r_w, peak_l_w} :
		32'h0000_0000;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_w;
			s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==========================================================
	// decimation select: 2'b01 for 64x, 2'b10 for 128x
	assign decim_sel = ctrl_q[CTRL_OS_HI] ? 2'b10 : 2'b01;
	// filter-start pulse resyncs filter and dividers
	assign filter_resync = filter_start_q;

	audio_clkgen u_clk (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.os_hi     (ctrl_q[CTRL_OS_HI]),
		.slave     (ctrl_q[CTRL_SLAVE]),
		.resync    (filter_start_q),
		.bclk_pin  (bit_clock_in),
		.frame_pin (frame_clock_in),
		.clks      (clks),
		.bclk_oe_n (bit_clock_oe_n),
		.frame_oe_n(frame_clock_oe_n),
		.bclk_out  (bit_clock_out),
		.frame_out (frame_clock)
	);

	// ==========================================================
	// high-pass: DC estimate subtracted unless bypassed
	logic signed [35:0] dc_l_q;
	logic signed [35:0] dc_r_q;
	stereo_t            hp_w;
	stereo_t            full_w;
	stereo_t            lgd_w;
	stereo_t            hold_full_q;
	stereo_t            hold_lgd_q;
	logic               byp;
	assign byp = ctrl_q[CTRL_HPF_BYP];
	assign hp_w.left  = full_left - 24'(dc_l_q >>> HPF_SHIFT);
	assign hp_w.right = full_right - 24'(dc_r_q >>> HPF_SHIFT);
	// imposed offset added after the filter
	assign full_w.left  = (byp ? full_left : hp_w.left) + ofs_l_q;
	assign full_w.right = (byp ? full_right : hp_w.right) + ofs_r_q;
	assign lgd_w.left   = lgd_left + ofs_l_q;
	assign lgd_w.right  = lgd_right + ofs_r_q;

	// both channels latched together from one sample
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dc_l_q <= 36'sh0_0000_0000;
			dc_r_q <= 36'sh0_0000_0000;
			hold_full_q <= '0;
			hold_lgd_q <= '0;
		end else if (filter_start_q) begin
			dc_l_q <= 36'sh0_0000_0000;
			dc_r_q <= 36'sh0_0000_0000;
		end else if (sample_valid) begin
			dc_l_q <= dc_l_q + 36'(hp_w.left);
			dc_r_q <= dc_r_q + 36'(hp_w.right);
			hold_full_q <= full_w;
			hold_lgd_q <= lgd_w;
		end
	end

	// ==========================================================
	// peak monitors
	peak_meter u_pk_l (
		.sys_clk(sys_clk), .rstn(rstn), .sample_valid(sample_valid),
		.sample(full_left), .overflow(ovf_left), .update(peak_update_q),
		.bargraph(ctrl_q[CTRL_BARGRAPH]), .peak_level_bits(peak_l_w)
	);
	peak_meter u_pk_r (
		.sys_clk(sys_clk), .rstn(rstn), .sample_valid(sample_valid),
		.sample(full_right), .overflow(ovf_right), .update(peak_update_q),
		.bargraph(ctrl_q[CTRL_BARGRAPH]), .peak_level_bits(peak_r_w)
	);

	// ==========================================================
	// Serialiser: 32-bit shift word per channel, loaded on frame edge
	logic [31:0] sh1_q;
	logic [31:0] sh2_q;
	logic        i2s_dly_q;
	logic [31:0] ld1_w;
	logic [31:0] ld2_w;
	logic        i2s;
	stereo_t     pair_full_q;
	stereo_t     pair_lgd_q;
	assign i2s = ctrl_q[CTRL_I2S];
	// peak bits follow word when enabled; MSB first two's complement
	assign ld1_w = {clks.frame ? pair_full_q.right : hold_full_q.left,
		ctrl_q[CTRL_PEAK_APPEND_EN] ? (clks.frame ? peak_r_w : peak_l_w) : 8'h00};
	assign ld2_w = {clks.frame ? pair_lgd_q.right : hold_lgd_q.left,
		ctrl_q[CTRL_PEAK_APPEND_EN] ? (clks.frame ? peak_r_w : peak_l_w) : 8'h00};

	// I2S delays the MSB by one bit clock
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sh1_q <= 32'h0000_0000;
			sh2_q <= 32'h0000_0000;
			i2s_dly_q <= 1'b0;
			full_precision_out <= 1'b0;
			secondary_audio_out <= 1'b0;
			pair_full_q <= '0;
			pair_lgd_q <= '0;
		end else begin
			if (clks.frame_edge) begin
				sh1_q <= ld1_w;
				sh2_q <= ld2_w;
				i2s_dly_q <= i2s;
				// left start freezes the pair, so the right word is no newer
				if (!clks.frame) begin
					pair_full_q <= hold_full_q;
					pair_lgd_q <= hold_lgd_q;
				end
			end else if (clks.bclk_fall) begin
				if (i2s_dly_q)
					i2s_dly_q <= 1'b0;
				else begin
					sh1_q <= {sh1_q[30:0], 1'b0};
					sh2_q <= {sh2_q[30:0], 1'b0};
				end
			end
			if (clks.frame_edge) begin
				full_precision_out <= i2s ? 1'b0 : ld1_w[31];
				secondary_audio_out <= i2s ? 1'b0 : ld2_w[31];
			end else if (clks.bclk_fall) begin
				full_precision_out <= i2s_dly_q ? sh1_q[31] : sh1_q[30];
				secondary_audio_out <= i2s_dly_q ? sh2_q[31] : sh2_q[30];
			end
		end
	end

	// ==========================================================
	// Checks
	property p_lj_msb;
		@(posedge sys_clk) disable iff (!rstn)
		(clks.frame_edge && !i2s) |=> full_precision_out == $past(ld1_w[31]);
	endproperty
	a_lj_msb: assert property (p_lj_msb) else $error("LJ MSB not at edge");
	property p_i2s_gap;
		@(posedge sys_clk) disable iff (!rstn)
		(clks.frame_edge && i2s) |=> !full_precision_out;
	endproperty
	a_i2s_gap: assert property (p_i2s_gap) else $error("I2S MSB too early");
	property p_default_lo;
		@(posedge sys_clk) $rose(rstn) |-> decim_sel == 2'b01;
	endproperty
	a_default_lo: assert property (p_default_lo) else $error("reset not 64x");
	property p_decim;
		@(posedge sys_clk) disable iff (!rstn)
		decim_sel == (ctrl_q[CTRL_OS_HI] ? 2'b10 : 2'b01);
	endproperty
	a_decim: assert property (p_decim) else $error("decimation mismatch");
	property p_master_oe;
		@(posedge sys_clk) disable iff (!rstn)
		!ctrl_q[CTRL_SLAVE] |-> (!bit_clock_oe_n && !frame_clock_oe_n);
	endproperty
	a_master_oe: assert property (p_master_oe) else $error("master not driving");
	property p_ofs;
		@(posedge sys_clk) disable iff (!rstn)
		(sample_valid && byp && !filter_start_q) |=>
			hold_full_q.left == $past(full_left) + $past(ofs_l_q);
	endproperty
	a_ofs: assert property (p_ofs) else $error("offset not applied");
	property p_peak_append_off;
		@(posedge sys_clk) disable iff (!rstn)
		!ctrl_q[CTRL_PEAK_APPEND_EN] |-> ld1_w[7:0] == 8'h00;
	endproperty
	a_peak_append_off: assert property (p_peak_append_off) else $error("peak bits leaked");
	property p_resync;
		@(posedge sys_clk) disable iff (!rstn)
		(wr_fire && wa_w == CMD_ADDR && ws_w[0] && wd_w[CMD_FILTER_START]) |=> filter_resync;
	endproperty
	a_resync: assert property (p_resync) else $error("filter-start lost");
	c_write: cover property (@(posedge sys_clk) wr_fire);
	c_i2s: cover property (@(posedge sys_clk) clks.frame_edge && i2s);
	c_peak_update: cover property (@(posedge sys_clk) peak_update_q);
endmodule
`default_nettype wire

// >>> adc_serial_audio_port_ctrl_tb.sv
`default_nettype none
module adc_serial_audio_port_ctrl_tb
	import adc_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic               sys_clk = 0, rstn = 0, sv = 0, ovf_l = 0, slv = 0;
	logic [7:0]         awaddr = 0, araddr = 0, cyc = 0;
	logic [31:0]        wdata = 0, seed = 32'h0000_70b8, rdata, w1, w2;
	logic               awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic               awready, wready, bvalid, arready, rvalid, rsync, side;
	logic               bout, boe_n, fout, foe_n, sd1, sd2, g_b, g_f;
	logic [1:0]         bresp, rresp, decim_sel;
	logic signed [23:0] fl = 0, fr = 0, gl = 0, gr = 0;
	logic [15:0]        frames;
	int                 n_errors = 0, checks_done = 0, rs_cnt = 0;
	// Wire level: whoever has its enable active drives the pin
	wire logic          bclk_w = boe_n ? g_b : bout;
	wire logic          frm_w = foe_n ? g_f : fout;

	always #5 sys_clk = ~sys_clk;
	// Decimator pulses a new sample every 64 cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 8'h1;
		sv <= (cyc[5:0] == 6'h0);
		if (rsync === 1'b1) rs_cnt++;
	end

	adc_serial_audio_port_ctrl uut (.sys_clk(sys_clk), .rstn(rstn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sample_valid(sv), .full_left(fl), .full_right(fr), .lgd_left(gl), .lgd_right(gr),
		.ovf_left(ovf_l), .ovf_right(1'b0), .decim_sel(decim_sel), .filter_resync(rsync),
		.bit_clock_in(bclk_w), .bit_clock_out(bout), .bit_clock_oe_n(boe_n),
		.frame_clock_in(frm_w), .frame_clock(fout), .frame_clock_oe_n(foe_n),
		.full_precision_out(sd1), .secondary_audio_out(sd2));

	audio_rx_model rx (.sys_clk(sys_clk), .rstn(rstn), .slave(slv), .bclk(bclk_w),
		.frame(frm_w), .sd1(sd1), .sd2(sd2), .gen_bclk(g_b), .gen_frame(g_f),
		.word1_q(w1), .word2_q(w2), .side_q(side), .frames_q(frames));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Every wait gives up after 2000 cycles
	task automatic tmo(input int n);
		if (n > 2000) begin
			n_errors++;
			$display("Error %0t: wait timed out", $time);
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			tmo(n);
			n++;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 0;
			tmo(n);
			n++;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask
	task automatic wait_side(input logic s);
		int n = 0;
		logic [15:0] f;
		f = frames;
		do begin
			@(posedge sys_clk);
			tmo(n);
			n++;
		end while (frames == f || side !== s);
	endtask
	// Cycles between two rising edges of bit clock (f=0) or frame (f=1)
	task automatic per(input logic f, output int p);
		int n = 0;
		int k = 0;
		logic o, v;
		p = 0;
		o = f ? frm_w : bclk_w;
		while (k < 2) begin
			@(posedge sys_clk);
			v = f ? frm_w : bclk_w;
			if (k == 1) p++;
			if (v && !o) k++;
			o = v;
			tmo(n);
			n++;
		end
	endtask
	// Third word of side s, after new samples have settled through the port
	task automatic word_chk(input logic i2s, input logic s, input logic [23:0] e1,
		input logic [23:0] e2);
		logic [31:0] a, b;
		repeat (3) wait_side(s);
		a = i2s ? {w1[30:0], 1'b0} : w1;
		b = i2s ? {w2[30:0], 1'b0} : w2;
		chk(a[31:8], e1);
		chk(b[31:8], e2);
		chk(a[7:0], 0);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  c;
		logic [23:0] ol;
		int          p;
		repeat (8) @(posedge sys_clk);
		rstn <= 1;
		chk(decim_sel, 2'h1);
		chk({boe_n, foe_n}, 2'h0);
		// Both formats in both settings, HPF bypassed, random samples
		for (int i = 0; i < 4; i++) begin
			repeat (16) seed = lfsr(seed);
			c = 8'h08 | i[1:0];
			ol = (i == 3) ? {8'h0, seed[15:0]} : 24'h0;
			fl <= {{3{seed[20]}}, seed[20:0]};
			fr <= {{3{seed[31]}}, seed[31:11]};
			gl <= {{3{seed[25]}}, seed[25:5]};
			gr <= {{3{seed[9]}}, seed[29:9]};
			wr(CTRL_ADDR, {24'h0, c}, r);
			chk(r, RESP_OKAY);
			wr(OFS_L_ADDR, {8'h0, ol}, r);
			rd(CTRL_ADDR, d, r);
			chk(d[7:0], c);
			rd(STATUS_ADDR, d, r);
			chk(d[0], c[0]);
			chk(decim_sel, c[0] ? 2'h2 : 2'h1);
			per(0, p);
			chk(p, BCLK_DIV);
			per(1, p);
			chk(p, c[0] ? FRAME_DIV_HI : FRAME_DIV_LO);
			word_chk(c[1], 0, fl + ol, gl + ol);
			word_chk(c[1], 1, fr, gr);
		end
		// Slave: clocks come from the receiver
		wr(OFS_L_ADDR, 32'h0000_0000, r);
		// DC removal on: after filter-start a constant input is pulled down
		fl <= 24'sh40_0000;
		wr(CTRL_ADDR, 32'h0000_0000, r);
		wr(CMD_ADDR, 32'h0000_0001, r);
		repeat (3) wait_side(0);
		chk(w1[31:30] == 2'b00 && w1[31:8] < 24'h40_0000, 1);
		slv <= 1;
		wr(CTRL_ADDR, 32'h0000_000D, r);
		chk({boe_n, foe_n}, 2'h3);
		word_chk(0, 0, fl, gl);
		slv <= 0;
		// Filter start pulses once; the peak-update write adds no resync pulse
		// host sends filter-start first, just after an edge
		p = rs_cnt;
		wr(CMD_ADDR, 32'h0000_0001, r);
		wr(CMD_ADDR, 32'h0000_0002, r);
		repeat (4) @(posedge sys_clk);
		chk(rs_cnt - p, 1);
		wr(PEAK_ADDR, 32'h0000_00FF, r);
		chk(r, RESP_SLVERR);
		rd(8'h40, d, r);
		chk(d, 32'h0000_0000);
		chk(r, RESP_SLVERR);
		// Peak capture: left overflows, right silent, in both formats
		fr <= 0;
		repeat (70) @(posedge sys_clk);
		for (int b = 0; b < 2; b++) begin
			wr(CTRL_ADDR, {27'h0, b[0], 4'h8}, r);
			wr(CMD_ADDR, 32'h0000_0002, r);
			ovf_l <= 1;
			repeat (200) @(posedge sys_clk);
			ovf_l <= 0;
			wr(CMD_ADDR, 32'h0000_0002, r);
			rd(PEAK_ADDR, d, r);
			if (b) chk(d[15:0], 16'h00FF);
			else chk({d[15:14], d[7]}, 3'h3);
		end
		repeat (200) @(posedge sys_clk);
		wr(CMD_ADDR, 32'h0000_0002, r);
		rd(PEAK_ADDR, d, r);
		chk(d[7], 0);
		finish_test();
	end
endmodule
`default_nettype wire

// >>> audio_clkgen.sv
`default_nettype none
module audio_clkgen
	import adc_port_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rstn,
	input  wire logic os_hi,
	input  wire logic slave,
	input  wire logic resync,
	input  wire logic bclk_pin,
	input  wire logic frame_pin,
	output clk_bus_t  clks,
	output logic      bclk_oe_n,
	output logic      frame_oe_n,
	output logic      bclk_out,
	output logic      frame_out
);
	// ==========================================================
	// Master divider: bit clock mclk/4, frame mclk/256 or /512
	logic [8:0] div_q;
	logic [1:0] bs_q;
	logic [1:0] fs_q;
	logic       bprev_q;
	logic       fprev_q;
	logic       bclk_w;
	logic       frame_w;
	logic       frame_m;

	// divider ratios; one counter serves both so edges align
	assign frame_m = os_hi ? div_q[8] : div_q[7];
	assign bclk_w  = slave ? bs_q[1] : div_q[1];
	assign frame_w = slave ? fs_q[1] : frame_m;
	assign bclk_oe_n  = slave;
	assign frame_oe_n = slave;
	assign bclk_out   = div_q[1];
	assign frame_out  = frame_m;
	assign clks.bclk       = bclk_w;
	assign clks.frame      = frame_w;
	assign clks.frame_edge = frame_w != fprev_q;
	assign clks.bclk_fall  = bprev_q & ~bclk_w;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			div_q <= 9'h000;
			bs_q <= 2'b00;
			fs_q <= 2'b00;
			bprev_q <= 1'b0;
			fprev_q <= 1'b0;
		end else begin
			div_q <= resync ? 9'h000 : div_q + 9'h001;
			bs_q <= {bs_q[0], bclk_pin};
			fs_q <= {fs_q[0], frame_pin};
			bprev_q <= bclk_w;
			fprev_q <= frame_w;
		end
	end

	property p_resync;
		@(posedge sys_clk) disable iff (!rstn)
		resync |=> div_q == 9'h000;
	endproperty
	a_resync: assert property (p_resync) else $error("divider not resynced");
	// Mode must hold across the edge, so a control write cannot trip these
	property p_lo_frame;
		@(posedge sys_clk) disable iff (!rstn)
		(!os_hi && !resync && div_q == 9'h07F) ##1 !os_hi |-> frame_out;
	endproperty
	a_lo_frame: assert property (p_lo_frame) else $error("frame /256 wrong");
	property p_hi_frame;
		@(posedge sys_clk) disable iff (!rstn)
		(os_hi && !resync && div_q == 9'h0FF) ##1 os_hi |-> frame_out;
	endproperty
	a_hi_frame: assert property (p_hi_frame) else $error("frame /512 wrong");
endmodule
`default_nettype wire

// >>> audio_rx_model.sv
`default_nettype none
// ==========================================================
// Serial audio receiver standing on the far side of the port
module audio_rx_model
	import adc_port_pkg::*;
(
	input  wire logic   sys_clk,
	input  wire logic   rstn,
	input  wire logic   slave,
	input  wire logic   bclk,
	input  wire logic   frame,
	input  wire logic   sd1,
	input  wire logic   sd2,
	output logic        gen_bclk,
	output logic        gen_frame,
	output logic [31:0] word1_q,
	output logic [31:0] word2_q,
	output logic        side_q,
	output logic [15:0] frames_q
);
	logic [8:0]  div_q;
	logic [31:0] sr1_q;
	logic [31:0] sr2_q;
	logic [5:0]  cnt_q;
	logic        bp_q;
	logic        fp_q;

	// slave clock source
	// Frame is 512 master clocks, bit clock 64x; both stand still in master
	assign gen_bclk  = div_q[2];
	assign gen_frame = div_q[8];
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) div_q <= '0;
		else if (slave) div_q <= div_q + 9'h1;
	end

	// Sample on bit clock rises; a frame edge closes the word of that half
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			{bp_q, fp_q, cnt_q, sr1_q, sr2_q} <= '0;
			{word1_q, word2_q, side_q, frames_q} <= '0;
		end else begin
			bp_q <= bclk;
			fp_q <= frame;
			if (frame != fp_q) begin
				word1_q  <= sr1_q;
				word2_q  <= sr2_q;
				side_q   <= fp_q;
				cnt_q    <= '0;
				frames_q <= frames_q + 16'h1;
			end else if (bclk && !bp_q && cnt_q < 6'h20) begin
				sr1_q <= {sr1_q[30:0], sd1};
				sr2_q <= {sr2_q[30:0], sd2};
				cnt_q <= cnt_q + 6'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> peak_meter.sv
`default_nettype none
module peak_meter
	import adc_port_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               rstn,
	input  wire logic               sample_valid,
	input  wire logic signed [23:0] sample,
	input  wire logic               overflow,
	input  wire logic               update,
	input  wire logic               bargraph,
	output logic [7:0]              peak_level_bits
);
	// ==========================================================
	// Magnitude and attenuation from leading-zero count
	logic [23:0] mag_w;
	logic [23:0] act_q;
	logic [23:0] act_d;
	logic        ovf_q;
	logic [7:0]  code_w;
	assign mag_w = sample[23] ? 24'(~sample) : 24'(sample);

	// Approx 6 dB per bit; cheap meter, accuracy traded for area
	function automatic logic [7:0] enc(input logic [23:0] m, input logic ov,
			input logic bar);
		logic [5:0] att;
		logic       idle;
		att = 6'd0;
		for (int i = 0; i < 23; i++) begin
			if (m[22-i] == 1'b0 && att == 6'(i))
				att = 6'(i + 1);
		end
		att  = (att > 6'd10) ? 6'd60 : 6'(att * 6);
		idle = (att >= 6'd60);
		if (!bar)
			enc = {ov, idle, att};
		else if (ov)
			enc = 8'hFF;
		else if (att < 6'd3)
			enc = 8'h7F;
		else if (att < 6'd6)
			enc = 8'h3F;
		else if (att < 6'd10)
			enc = 8'h1F;
		else if (att < 6'd20)
			enc = 8'h0F;
		else if (att < 6'd30)
			enc = 8'h07;
		else if (att < 6'd40)
			enc = 8'h03;
		else if (att < 6'd60)
			enc = 8'h01;
		else
			enc = 8'h00;
	endfunction

	assign code_w = enc(act_q, ovf_q, bargraph);
	// peak tracking; a sample landing with the update seeds the new peak
	assign act_d = update ? (sample_valid ? mag_w : 24'h00_0000) :
		(sample_valid && mag_w > act_q) ? mag_w : act_q;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			act_q <= 24'h00_0000;
			ovf_q <= 1'b0;
			peak_level_bits <= 8'h00;
		end else begin
			act_q <= act_d;
			ovf_q <= (update ? 1'b0 : ovf_q) | (sample_valid & overflow); // Set wins
			if (update)
				peak_level_bits <= code_w;
		end
	end

	property p_update_clears;
		@(posedge sys_clk) disable iff (!rstn)
		update |=> act_q == ($past(sample_valid) ? $past(mag_w) : 24'h00_0000);
	endproperty
	a_update_clears: assert property (p_update_clears) else $error("active peak not cleared");
endmodule
`default_nettype wire
